/* logic/haptic_device.sv */
// Purpose: Memory playback and event controller, device end of link
// Assumes: Event inputs are one-cycle pulses on hclk
// Notes:   Register access only through link frames
// Contract
// - Register mode plays only on start write
// - Edge mode starts on pin edge or write
// - Host sets selector and repeats while idle
// - Held mode value needs no rewrite
// - Repeat write in drive restarts, raises event
// - Done sets flag, interrupt, goes idle/standby
// - Writing zero mode or start stops
// - Host configures pin sequence, multi, edge
// - Host loads snippets and timebase first
// - Access bit zero refuses memory access
// - Faults force idle; others only inform
// - Events pull open-drain interrupt low
// - Fault byte plus warning, input details
// - Five fault flags in summary byte
// - Input faults set playback fault flag
// - Four notification flags
// - Three warning flags
// - Three input faults; write one clears
// - Write one clears; two masks gate
// - Mode zero is inactive low power
// - Standby bit picks idle or standby
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module haptic_device
  import haptic_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [9:0] event_in,
  output logic            drive_active,
  output logic [3:0]      drive_seq,
  output logic [1:0]      power_state,
  haptic_link_if.device   link
);
  logic scl_lv, scl_rise, scl_fall, sda_lv, sda_rise, sda_fall;
  logic trg_rise, trg_fall;
  logic        active_q, rd_flag_q, sda_oe_q, irq_oe_q;
  logic [4:0]  cnt_q;
  logic [15:0] shreg_q;
  logic [7:0]  rdata_q, rd_val;
  logic [7:0]  fault_q, notif_q, warn_q, sdiag_q, mask1_q, mask2_q;
  logic [2:0]  mode_q;
  logic        stby_q, tmulti_q, unlock_q;
  logic [3:0]  seqid_q, loop_q, tsel_q, loops_q, pseq_q;
  logic [1:0]  tedge_q, tb_q;
  logic [6:0]  ptr_q;
  logic [7:0]  mem_q [MEM_DEPTH];
  logic [7:0]  rem_q;
  logic [15:0] tbcnt_q;
  play_state_t st_q, rest;

  // Set wins over clear for every event flag
  function automatic logic [7:0] w1c(input logic [7:0] f,
                                     input logic [7:0] s,
                                     input logic [7:0] c);
    w1c = (f & ~c) | s;
  endfunction

  sync_edge #(.INIT(1'b1)) u_scl (.clk(hclk), .rst_n(hresetn),
    .din(link.scl), .level(scl_lv), .rise(scl_rise), .fall(scl_fall));
  sync_edge #(.INIT(1'b1)) u_sda (.clk(hclk), .rst_n(hresetn),
    .din(link.sda), .level(sda_lv), .rise(sda_rise), .fall(sda_fall));
  sync_edge #(.INIT(1'b0)) u_trg (.clk(hclk), .rst_n(hresetn),
    .din(link.general_input_pin), .level(), .rise(trg_rise),
    .fall(trg_fall));

  // Frame decode
  wire       start_det = sda_fall & scl_lv;
  wire       stop_det  = sda_rise & scl_lv;
  wire [7:0] hdr       = {shreg_q[6:0], sda_lv};
  wire       bit_in    = active_q & scl_rise & (cnt_q < 5'd16);
  wire       wr_stb    = bit_in & (cnt_q == 5'd15) & ~shreg_q[14];
  wire [6:0] wr_idx    = shreg_q[13:7];
  wire [7:0] wr_dat    = hdr;

  // Frame receiver: start, stop and bit shifting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_q  <= 1'b0;
      cnt_q     <= 5'h00;
      shreg_q   <= 16'h0000;
      rd_flag_q <= 1'b0;
      rdata_q   <= 8'h00;
    end else if (start_det) begin
      active_q <= 1'b1;
      cnt_q    <= 5'h00;
    end else if (stop_det) begin
      active_q <= 1'b0;
    end else if (bit_in) begin
      shreg_q <= {shreg_q[14:0], sda_lv};
      cnt_q   <= cnt_q + 5'd1;
      if (cnt_q == 5'd7) begin
        rd_flag_q <= hdr[7];
        rdata_q   <= rd_val;
      end
    end
  end

  // Read bits out while clock low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_oe_q <= 1'b0;
    end else if (!active_q || start_det || stop_det) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      sda_oe_q <= rd_flag_q & (cnt_q >= 5'd8) & (cnt_q < 5'd16)
                  & ~rdata_q[3'(5'd15 - cnt_q)];
    end
  end

  // Playback control terms
  wire wr_ctrl   = wr_stb & (wr_idx == R_CTRL);
  wire wr_start1 = wr_ctrl & wr_dat[B_START];
  wire wr_rep1   = wr_ctrl & wr_dat[B_REPEAT];
  wire stop_req  = (wr_ctrl & ~wr_dat[B_START]) |
                   (wr_stb & (wr_idx == R_MODE) & (wr_dat[2:0] == MODE_INACTIVE));
  wire mem_mode  = (mode_q == MODE_REG) | (mode_q == MODE_EDGE);
  wire trig_hit  = tmulti_q ? (trg_rise | trg_fall) :
                   (tedge_q == EDGE_RISE) ? trg_rise :
                   (tedge_q == EDGE_FALL) ? trg_fall :
                   (tedge_q == EDGE_BOTH) & (trg_rise | trg_fall);
  wire [3:0] trig_seq = (tmulti_q & trg_fall) ? tsel_q + 4'd1 : tsel_q;
  wire req = (wr_start1 & mem_mode) | (trig_hit & (mode_q == MODE_EDGE));
  wire [3:0] req_seq  = wr_start1 ? seqid_q : trig_seq;
  wire [7:0] seq_len  = mem_q[req_seq];
  wire fault_pend     = |fault_q;
  wire can_go   = req & (st_q != ST_DRIVE) & ~fault_pend;
  wire go       = can_go & (seq_len != 8'h00);
  wire id_bad   = can_go & (seq_len == 8'h00);
  wire in_drive = (st_q == ST_DRIVE) & ~fault_pend & ~stop_req;
  wire tick     = (st_q == ST_DRIVE) & (tbcnt_q == 16'h0000);
  wire rep_set  = in_drive & wr_rep1;
  wire done_set = in_drive & ~wr_rep1 & tick & (rem_q <= 8'd1) &
                  (loops_q == 4'h0);
  wire [15:0] tb_reload = 16'(TB_BASE_CYC << tb_q) - 16'd1;

  always_comb begin
    rest = stby_q ? ST_STANDBY : ST_IDLE;
  end

  // Playback state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q    <= ST_IDLE;
      rem_q   <= 8'h00;
      loops_q <= 4'h0;
      pseq_q  <= 4'h0;
    end else if (fault_pend) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE, ST_STANDBY: begin
          if (go) begin
            st_q    <= ST_DRIVE;
            rem_q   <= seq_len;
            loops_q <= loop_q;
            pseq_q  <= req_seq;
          end
        end
        ST_DRIVE: begin
          if (stop_req) begin
            st_q <= rest;
          end else if (wr_rep1) begin
            rem_q <= mem_q[pseq_q];
          end else if (tick) begin
            if (rem_q > 8'd1) begin
              rem_q <= rem_q - 8'd1;
            end else if (loops_q != 4'h0) begin
              loops_q <= loops_q - 4'd1;
              rem_q   <= mem_q[pseq_q];
            end else begin
              st_q <= rest;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Timebase enable divider
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tbcnt_q <= 16'h0000;
    end else if (st_q != ST_DRIVE || tbcnt_q == 16'h0000) begin
      tbcnt_q <= tb_reload;
    end else begin
      tbcnt_q <= tbcnt_q - 16'd1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_q <= 8'h00;
      notif_q <= 8'h00;
      warn_q  <= 8'h00;
      sdiag_q <= 8'h00;
    end else begin
      fault_q <= w1c(fault_q,
        8'(event_in[EV_OC]) << F_OC | 8'(event_in[EV_ACT]) << F_ACT |
        8'(id_bad | event_in[EV_MEMF] | event_in[EV_PWMF]) << F_SEQ |
        8'(event_in[EV_THERM]) << F_THERM | 8'(event_in[EV_UVLO]) << F_UVLO,
        (wr_stb && wr_idx == R_FAULT) ? wr_dat : 8'h00);
      notif_q <= w1c(notif_q,
        8'(done_set) << N_DONE | 8'(rep_set) << N_REP |
        8'(event_in[EV_ADC]) << N_ADC,
        (wr_stb && wr_idx == R_NOTIF) ? wr_dat : 8'h00);
      warn_q <= w1c(warn_q,
        8'(event_in[EV_DLIM]) << W_DLIM | 8'(event_in[EV_OLIM]) << W_OLIM |
        8'(event_in[EV_MTYPE]) << W_MTYPE,
        (wr_stb && wr_idx == R_WARN) ? wr_dat : 8'h00);
      sdiag_q <= w1c(sdiag_q,
        8'(id_bad) << S_ID | 8'(event_in[EV_MEMF]) << S_MEM |
        8'(event_in[EV_PWMF]) << S_PWM,
        (wr_stb && wr_idx == R_SDIAG) ? wr_dat : 8'h00);
    end
  end

  // Notification byte with live warning summary
  wire [7:0] notif_all = notif_q | (8'(|warn_q) << N_WARN);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_oe_q <= 1'b0;
    end else begin
      irq_oe_q <= |(fault_q & ~mask1_q) | |(notif_all & ~mask2_q);
    end
  end

  // Configuration registers; mode zero is inactive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask1_q <= RST_MASK;
      mask2_q <= RST_MASK;
      mode_q  <= MODE_INACTIVE;
      stby_q  <= 1'b0;
      seqid_q <= 4'h0;
      loop_q  <= 4'h0;
      tsel_q  <= 4'h0;
      tmulti_q <= 1'b0;
      tedge_q <= EDGE_RISE;
      unlock_q <= 1'b0;
      tb_q    <= 2'h0;
    end else if (wr_stb) begin
      case (wr_idx)
        R_MASK1: mask1_q <= wr_dat;
        R_MASK2: mask2_q <= wr_dat;
        R_MODE: begin
          mode_q <= wr_dat[2:0];
          stby_q <= wr_dat[3];
        end
        R_SEQID: seqid_q <= wr_dat[3:0];
        R_LOOP:  loop_q  <= wr_dat[3:0];
        R_TRIG: begin
          tsel_q   <= wr_dat[3:0];
          tmulti_q <= wr_dat[4];
          tedge_q  <= wr_dat[6:5];
        end
        R_MEMCFG: begin
          unlock_q <= wr_dat[0];
          tb_q     <= wr_dat[2:1];
        end
        default: ;
      endcase
    end
  end

  // snippet memory write only when access bit set
  wire mem_ok = unlock_q & (ptr_q < 7'(MEM_DEPTH));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_q <= 7'h00;
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (wr_stb && wr_idx == R_MPTR) begin
      ptr_q <= wr_dat[6:0];
    end else if (wr_stb && wr_idx == R_MDATA && mem_ok) begin
      mem_q[ptr_q] <= wr_dat;
      ptr_q        <= ptr_q + 7'd1;
    end
  end

  // Read mux by frame header
  always_comb begin
    case (hdr[6:0])
      R_FAULT:  rd_val = fault_q;
      R_NOTIF:  rd_val = notif_all;
      R_WARN:   rd_val = warn_q;
      R_SDIAG:  rd_val = sdiag_q;
      R_MASK1:  rd_val = mask1_q;
      R_MASK2:  rd_val = mask2_q;
      R_MODE:   rd_val = {4'h0, stby_q, mode_q};
      R_CTRL:   rd_val = {7'h00, st_q == ST_DRIVE};
      R_SEQID:  rd_val = {4'h0, seqid_q};
      R_LOOP:   rd_val = {4'h0, loop_q};
      R_TRIG:   rd_val = {1'b0, tedge_q, tmulti_q, tsel_q};
      R_MEMCFG: rd_val = {5'h00, tb_q, unlock_q};
      R_STATE:  rd_val = {6'h00, 2'(st_q)};
      R_MPTR:   rd_val = {1'b0, ptr_q};
      R_MDATA:  rd_val = mem_ok ? mem_q[ptr_q] : 8'h00;
      default:  rd_val = 8'h00;
    endcase
  end

  // Registered user-side outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_active <= 1'b0;
      drive_seq    <= 4'h0;
      power_state  <= 2'h0;
    end else begin
      drive_active <= st_q == ST_DRIVE;
      drive_seq    <= pseq_q;
      power_state  <= 2'(st_q);
    end
  end

  assign link.sda_dev_o  = 1'b0;
  assign link.sda_dev_oe = sda_oe_q;
  assign link.irq_o      = 1'b0;
  assign link.irq_oe     = irq_oe_q;
endmodule
`default_nettype wire

/* logic/haptic_pkg.sv */
// Purpose: Shared constants and types for the haptic playback link
// Assumes: 200 MHz hclk; 7-bit register index, 8-bit data on the link
// Notes:   Frame = read flag, 7-bit index, 8 data bits, MSB first
package haptic_pkg;
  // Clock and link timing
  localparam int CLK_NS         = 5;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / 2 / CLK_NS;
  localparam int TB_BASE_CYC    = 200;
  localparam int FRAME_BITS     = 16;
  localparam int MEM_DEPTH      = 100;

  // Device register indexes
  localparam logic [6:0] R_FAULT  = 7'h00;
  localparam logic [6:0] R_NOTIF  = 7'h01;
  localparam logic [6:0] R_WARN   = 7'h02;
  localparam logic [6:0] R_SDIAG  = 7'h03;
  localparam logic [6:0] R_MASK1  = 7'h04;
  localparam logic [6:0] R_MASK2  = 7'h05;
  localparam logic [6:0] R_MODE   = 7'h06;
  localparam logic [6:0] R_CTRL   = 7'h07;
  localparam logic [6:0] R_SEQID  = 7'h08;
  localparam logic [6:0] R_LOOP   = 7'h09;
  localparam logic [6:0] R_TRIG   = 7'h0a;
  localparam logic [6:0] R_MEMCFG = 7'h0b;
  localparam logic [6:0] R_STATE  = 7'h0c;
  localparam logic [6:0] R_MPTR   = 7'h0d;
  localparam logic [6:0] R_MDATA  = 7'h0e;

  // Field positions and encodings
  localparam int B_START  = 0;
  localparam int B_REPEAT = 1;
  localparam logic [2:0] MODE_INACTIVE = 3'h0;
  localparam logic [2:0] MODE_REG      = 3'h3;
  localparam logic [2:0] MODE_EDGE     = 3'h4;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [7:0] RST_MASK  = 8'h00;

  // Event input positions
  localparam int EV_OC = 0, EV_ACT = 1, EV_THERM = 2, EV_UVLO = 3;
  localparam int EV_ADC = 4, EV_DLIM = 5, EV_OLIM = 6, EV_MTYPE = 7;
  localparam int EV_MEMF = 8, EV_PWMF = 9;
  // Event byte bit positions
  localparam int F_OC = 0, F_ACT = 1, F_SEQ = 2, F_THERM = 3, F_UVLO = 4;
  localparam int N_DONE = 0, N_REP = 1, N_WARN = 2, N_ADC = 3;
  localparam int W_DLIM = 0, W_OLIM = 1, W_MTYPE = 2;
  localparam int S_ID = 0, S_MEM = 1, S_PWM = 2;

  // Host register byte offsets
  localparam logic [31:0] HR_CMD  = 32'h0000_0000;
  localparam logic [31:0] HR_STAT = 32'h0000_0004;
  localparam logic [31:0] HR_TRIG = 32'h0000_0008;

  typedef enum logic [1:0] {ST_IDLE, ST_STANDBY, ST_DRIVE} play_state_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} host_state_t;
endpackage

/* logic/haptic_link_if.sv */
// Purpose: Wires between host and device: clock, data, irq, trigger
// Assumes: Data and interrupt lines are open-drain with pull-up
// Notes:   Resolves bus levels from the drivers' enables
`timescale 1ns/1ps
`default_nettype none
interface haptic_link_if;
  logic scl;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda;
  logic irq_o;
  logic irq_oe;
  logic interrupt_out_n;
  logic general_input_pin;

  // Open-drain resolution with pull-up
  assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));
  assign interrupt_out_n = ~(irq_oe & ~irq_o);

  modport host (output scl, output sda_host_o, output sda_host_oe,
                output general_input_pin, input sda, input interrupt_out_n);
  modport device (output sda_dev_o, output sda_dev_oe, output irq_o,
                  output irq_oe, input scl, input sda,
                  input general_input_pin);
endinterface
`default_nettype wire

/* logic/sync_edge.sv */
// Purpose: Three-stage input synchroniser with edge pulses
// Assumes: Input is asynchronous to clk
// Notes:   Level changes only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sync_edge #(
  parameter logic INIT = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Stage chain; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Qualified level and one-cycle edge pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= INIT;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      if (s2_q == s3_q) begin
        level <= s2_q;
      end
      rise <= (s2_q == s3_q) & s2_q & ~level;
      fall <= (s2_q == s3_q) & ~s2_q & level;
    end
  end
endmodule
`default_nettype wire

/* logic/link_host.sv */
// Purpose: Host end: AHB-Lite registers driving link frames and trigger
// Assumes: Zero-wait AHB-Lite slave, word accesses only
// Notes:   Link clock is divided from hclk; one frame at a time
`timescale 1ns/1ps
`default_nettype none
module link_host
  import haptic_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  haptic_link_if.host      link
);
  logic        wr_pend_q, scl_q, sda_oe_q, trig_q, sda_lv, irq_lv;
  logic [31:0] waddr_q;
  logic [15:0] frame_q;
  logic [7:0]  rdata_q;
  logic [4:0]  hcnt_q, bit_q;
  logic [1:0]  ph_q;
  logic [31:0] rd_mux;
  host_state_t hst_q;

  sync_edge #(.INIT(1'b1)) u_sda (.clk(hclk), .rst_n(hresetn),
    .din(link.sda), .level(sda_lv), .rise(), .fall());
  sync_edge #(.INIT(1'b1)) u_irq (.clk(hclk), .rst_n(hresetn),
    .din(link.interrupt_out_n), .level(irq_lv), .rise(), .fall());

  wire acc  = hsel & hready & htrans[1];
  wire busy = hst_q != H_IDLE;
  wire tick = hcnt_q == 5'h00;
  wire cmd  = wr_pend_q & (waddr_q == HR_CMD) & ~busy;
  wire rd_bit = frame_q[15] & (bit_q >= 5'd8);

  // Read data for the current address phase
  always_comb begin
    case (haddr)
      HR_CMD:  rd_mux = {16'h0000, frame_q};
      HR_STAT: rd_mux = {16'h0000, rdata_q, 6'h00, ~irq_lv, busy};
      HR_TRIG: rd_mux = {31'h0000_0000, trig_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // AHB slave, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      waddr_q   <= 32'h0000_0000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= acc & hwrite & (hsize == 3'h2);
      waddr_q   <= haddr;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Trigger pin level register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_q <= 1'b0;
    end else if (wr_pend_q && waddr_q == HR_TRIG) begin
      trig_q <= hwdata[0];
    end
  end

  // Half-period enable for the link clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hcnt_q <= 5'h00;
    end else begin
      hcnt_q <= tick ? 5'(LINK_HALF_CYC - 1) : hcnt_q - 5'd1;
    end
  end

  // Frame engine: start, 16 bits, stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hst_q    <= H_IDLE;
      scl_q    <= 1'b1;
      sda_oe_q <= 1'b0;
      frame_q  <= 16'h0000;
      rdata_q  <= 8'h00;
      bit_q    <= 5'h00;
      ph_q     <= 2'h0;
    end else begin
      case (hst_q)
        H_IDLE: begin
          if (cmd) begin
            frame_q <= hwdata[15:0];
            hst_q   <= H_START;
          end
        end
        H_START: begin
          if (tick) begin
            sda_oe_q <= 1'b1;
            bit_q    <= 5'h00;
            ph_q     <= 2'h0;
            hst_q    <= H_BITS;
          end
        end
        H_BITS: begin
          if (tick) begin
            case (ph_q)
              2'h0: begin
                scl_q <= 1'b0;
                ph_q  <= 2'h1;
              end
              2'h1: begin
                sda_oe_q <= ~rd_bit & ~frame_q[4'(5'd15 - bit_q)];
                ph_q     <= 2'h2;
              end
              default: begin
                scl_q <= 1'b1;
                ph_q  <= 2'h0;
                if (rd_bit) begin
                  rdata_q <= {rdata_q[6:0], sda_lv};
                end
                if (bit_q == 5'(FRAME_BITS - 1)) begin
                  hst_q <= H_STOP;
                end else begin
                  bit_q <= bit_q + 5'd1;
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'd1;
            case (ph_q)
              2'h0: scl_q <= 1'b0;
              2'h1: sda_oe_q <= 1'b1;
              2'h2: scl_q <= 1'b1;
              default: begin
                sda_oe_q <= 1'b0;
                hst_q    <= H_IDLE;
              end
            endcase
          end
        end
        default: hst_q <= H_IDLE;
      endcase
    end
  end

  assign link.scl               = scl_q;
  assign link.sda_host_o        = 1'b0;
  assign link.sda_host_oe       = sda_oe_q;
  assign link.general_input_pin = trig_q;
endmodule
`default_nettype wire

/* verif/haptic_assertions.sv */
// Purpose: Link and playback checks
// Assumes: One hclk domain
// Notes:   Watches link wires and device outputs
`timescale 1ns/1ps
`default_nettype none
module haptic_assertions (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       scl,
  input  wire logic       sda_dev_oe,
  input  wire logic       irq_o,
  input  wire logic       irq_oe,
  input  wire logic       interrupt_out_n,
  input  wire logic [9:0] event_in,
  input  wire logic       drive_active,
  input  wire logic [1:0] power_state
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Half periods of the link clock and the fault reaction
  sequence low_half; !scl [*8]; endsequence
  sequence high_half; scl [*8]; endsequence
  sequence back_idle; ##[1:4] power_state == 2'h0; endsequence
  a_scl_low_half: assert property ($fell(scl) |-> low_half)
    else $error("link clock low half too short");
  a_scl_high_half: assert property ($rose(scl) |-> high_half)
    else $error("link clock high half too short");
  a_dev_drive_low: assert property ($rose(sda_dev_oe) |-> !scl)
    else $error("device drives data while clock high");
  a_irq_pull_low: assert property (irq_oe |-> !interrupt_out_n)
    else $error("interrupt line not low when pulled");
  a_irq_drive_zero: assert property (irq_oe |-> !irq_o)
    else $error("interrupt driver not open drain");
  a_irq_release: assert property (!irq_oe |-> interrupt_out_n)
    else $error("interrupt line low while released");
  a_fault_to_idle: assert property (event_in[0] |-> back_idle)
    else $error("fault did not force idle");
  a_state_legal: assert property (power_state != 2'h3)
    else $error("power state out of range");
  a_drive_in_state: assert property (drive_active |->
    power_state == 2'h2 || $past(power_state) == 2'h2)
    else $error("drive flag outside drive state");
endmodule
`default_nettype wire

/* verif/tb_memory_playback_and_event_ctrl.sv */
// Purpose: Bench for host and device ends joined by the link
// Assumes: hclk 200 MHz, link clock made by the host
// Notes:   Row table first, then playback, mask and fault cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h not %h", $time, (a), (e)); end end
module tb_memory_playback_and_event_ctrl
  import haptic_pkg::*;
;
  typedef struct packed {
    logic [3:0] ev;
    logic [6:0] idx;
    logic [7:0] exp;
  } row_t;
  localparam logic [3:0] NO = 4'hf;
  logic        hclk = 0;
  logic        hresetn = 0;
  logic [31:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic        hwrite = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [9:0]  event_in = 0;
  logic        drive_active;
  logic [3:0]  drive_seq;
  logic [1:0]  power_state;
  logic [31:0] d;
  int          fails = 0;
  int          comparisons = 0;
  row_t        rows [21];
  haptic_link_if link_if ();
  link_host link_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .link(link_if.host));
  haptic_device haptic_device_i (.hclk(hclk), .hresetn(hresetn),
    .event_in(event_in), .drive_active(drive_active),
    .drive_seq(drive_seq), .power_state(power_state),
    .link(link_if.device));
  haptic_assertions haptic_assertions_i (.hclk(hclk), .hresetn(hresetn),
    .scl(link_if.scl), .sda_dev_oe(link_if.sda_dev_oe),
    .irq_o(link_if.irq_o), .irq_oe(link_if.irq_oe),
    .interrupt_out_n(link_if.interrupt_out_n), .event_in(event_in),
    .drive_active(drive_active), .power_state(power_state));
  // Clock
  always #2.5 hclk = ~hclk;
  // One AHB-Lite word transfer, read data left in d
  task automatic ahb(input logic w, input logic [31:0] a, wd);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  // One frame, poll until free
  task automatic link(input logic rd, input logic [6:0] i, input logic [7:0] v);
    ahb(1'b1, HR_CMD, {16'h0, rd, i, v});
    repeat (4) @(posedge hclk);
    do ahb(1'b0, HR_STAT, 32'h0); while (d[0] !== 1'b0);
  endtask
  task automatic wait_drive(input logic lvl);
    for (int i = 0; i < 9000 && drive_active !== lvl; i++) @(posedge hclk);
  endtask
  task automatic pulse(input logic [3:0] b);
    @(posedge hclk);
    event_in <= 10'h1 << b;
    @(posedge hclk);
    event_in <= 10'h0;
  endtask
  task automatic end_of_test;
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (100000) @(posedge hclk);
    fails++;
    end_of_test;
  end
  // Main sequence
  initial begin
    rows = '{'{NO, R_MASK1, 8'h1f}, '{NO, R_MASK2, 8'h0f},
      '{NO, R_SEQID, 8'h03}, '{NO, R_LOOP, 8'h02},
      '{NO, R_TRIG, 8'h45}, '{NO, R_MASK1, 8'h00},
      '{NO, R_MASK2, 8'h00}, '{NO, R_SEQID, 8'h00},
      '{NO, R_LOOP, 8'h00}, '{4'h0, R_FAULT, 8'h01},
      '{4'h1, R_FAULT, 8'h02}, '{4'h2, R_FAULT, 8'h08},
      '{4'h3, R_FAULT, 8'h10}, '{4'h4, R_NOTIF, 8'h08},
      '{4'h5, R_NOTIF, 8'h04}, '{4'h5, R_WARN, 8'h01},
      '{4'h6, R_WARN, 8'h02}, '{4'h7, R_WARN, 8'h04},
      '{4'h8, R_FAULT, 8'h04}, '{4'h8, R_SDIAG, 8'h02},
      '{4'h9, R_SDIAG, 8'h04}};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    link(1'b1, R_MASK1, 8'h00);
    `CHK(d[15:8], RST_MASK);
    link(1'b1, R_MODE, 8'h00);
    `CHK(d[15:8], 8'h00);
    `CHK(link_if.interrupt_out_n, 1'b1);
    // Register rows and event rows
    foreach (rows[i]) begin
      if (rows[i].ev == NO) link(1'b0, rows[i].idx, rows[i].exp);
      else pulse(rows[i].ev);
      link(1'b1, rows[i].idx, 8'h00);
      `CHK(d[15:8], rows[i].exp);
      if (rows[i].ev != NO) begin
        link(1'b0, rows[i].idx, 8'hff);
        link(1'b0, R_FAULT, 8'hff);
      end
    end
    // Memory refused shut, then loaded
    link(1'b0, R_MDATA, 8'h02);
    link(1'b0, R_MEMCFG, 8'h05);
    link(1'b0, R_MPTR, 8'h00);
    link(1'b1, R_MDATA, 8'h00);
    `CHK(d[15:8], 8'h00);
    link(1'b0, R_MPTR, 8'h00);
    link(1'b0, R_MDATA, 8'h02);
    link(1'b0, R_MPTR, 8'h00);
    link(1'b1, R_MDATA, 8'h00);
    `CHK(d[15:8], 8'h02);
    // Register mode: start, repeat, completion
    link(1'b0, R_MODE, {5'h0, MODE_REG});
    repeat (400) @(posedge hclk);
    `CHK(power_state, 2'h0);
    link(1'b0, R_CTRL, 8'h01);
    wait_drive(1'b1);
    `CHK(drive_seq, 4'h0);
    link(1'b0, R_CTRL, 8'h03);
    wait_drive(1'b0);
    link(1'b1, R_NOTIF, 8'h00);
    `CHK(d[15:8], 8'h03);
    `CHK(link_if.interrupt_out_n, 1'b0);
    `CHK(power_state, 2'h0);
    link(1'b0, R_NOTIF, 8'h03);
    repeat (20) @(posedge hclk);
    `CHK(link_if.interrupt_out_n, 1'b1);
    // Restart with the mode kept, then stop by start bit 0
    link(1'b0, R_CTRL, 8'h01);
    wait_drive(1'b1);
    `CHK(drive_active, 1'b1);
    link(1'b0, R_CTRL, 8'h00);
    repeat (20) @(posedge hclk);
    `CHK(drive_active, 1'b0);
    // Standby after playback, completion masked
    link(1'b0, R_MASK2, 8'h01);
    link(1'b0, R_MODE, 8'h0b);
    link(1'b0, R_CTRL, 8'h01);
    wait_drive(1'b1);
    wait_drive(1'b0);
    repeat (20) @(posedge hclk);
    `CHK(power_state, 2'h1);
    `CHK(link_if.interrupt_out_n, 1'b1);
    link(1'b1, R_NOTIF, 8'h00);
    `CHK(d[15:8], 8'h01);
    // Pin start, fault, start refused
    link(1'b0, R_TRIG, 8'h00);
    link(1'b0, R_MODE, {5'h0, MODE_EDGE});
    ahb(1'b1, HR_TRIG, 32'h1);
    wait_drive(1'b1);
    `CHK(drive_active, 1'b1);
    pulse(EV_OC);
    repeat (10) @(posedge hclk);
    `CHK(power_state, 2'h0);
    link(1'b0, R_CTRL, 8'h01);
    repeat (20) @(posedge hclk);
    `CHK(drive_active, 1'b0);
    link(1'b0, R_FAULT, 8'hff);
    link(1'b0, R_CTRL, 8'h01);
    wait_drive(1'b1);
    `CHK(drive_active, 1'b1);
    end_of_test;
  end
endmodule
`default_nettype wire
